// file: hdl/bcsu_compare.sv
// Subtract-and-flag unit for the compare instructions
`timescale 1ns/1ps
`default_nettype none
module bcsu_compare
    import bcsu_pkg::*;
(
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic use_carry,
    input wire logic [7:0] status_register_in,
    output logic [7:0] status_register_out
);
    logic [7:0] r;
    logic cin;
    // ------------------------------------------------------------
    // Difference and flags
    // ------------------------------------------------------------
    always_comb begin
        cin = use_carry & status_register_in[FLAG_C];
        r = a - b - {7'h00, cin};
        status_register_out = status_register_in;
        status_register_out[FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
        status_register_out[FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
        status_register_out[FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        status_register_out[FLAG_N] = r[7];
        status_register_out[FLAG_S] = r[7] ^ status_register_out[FLAG_V];
        // Carry variant keeps zero only if all earlier bytes were zero
        status_register_out[FLAG_Z] = (r == 8'h00) & (~use_carry | status_register_in[FLAG_Z]);
    end
endmodule // bcsu_compare
`default_nettype wire

// file: hdl/bcsu_decode.sv
// Opcode classifier for the branch, call and skip unit
`timescale 1ns/1ps
`default_nettype none
module bcsu_decode
    import bcsu_pkg::*;
(
    input wire logic [15:0] instr,
    output bcsu_op_t op
);
    // ------------------------------------------------------------
    // Classification
    // ------------------------------------------------------------
    always_comb begin
        op = OP_ILLEGAL;
        if ((instr & MSK_REL_CALL) == PAT_REL_CALL) begin
            op = OP_REL_CALL;
        end else if (instr == PAT_IND_CALL) begin
            op = OP_IND_CALL;
        end else if ((instr & MSK_DIR_CALL) == PAT_DIR_CALL) begin
            op = OP_DIR_CALL;
        end else if (instr == PAT_SUB_RET) begin
            op = OP_SUB_RET;
        end else if (instr == PAT_INT_RET) begin
            op = OP_INT_RET;
        end else if ((instr & MSK_REG2) == PAT_CMP_SKIP) begin
            op = OP_CMP_SKIP;
        end else if ((instr & MSK_REG2) == PAT_CMP) begin
            op = OP_CMP;
        end else if ((instr & MSK_REG2) == PAT_CMP_CARRY) begin
            op = OP_CMP_CARRY;
        end else if ((instr & MSK_REL_CALL) == PAT_CMP_IMM) begin
            op = OP_CMP_IMM;
        end else if ((instr & MSK_SKIP_REG) == PAT_SKIP_RBC) begin
            op = OP_SKIP_RBC;
        end else if ((instr & MSK_SKIP_REG) == PAT_SKIP_RBS) begin
            op = OP_SKIP_RBS;
        end else if ((instr & MSK_SKIP_IO) == PAT_SKIP_IOC) begin
            op = OP_SKIP_IOC;
        end else if ((instr & MSK_SKIP_IO) == PAT_SKIP_IOS) begin
            op = OP_SKIP_IOS;
        end else if ((instr & MSK_REG2) == PAT_BR_SET) begin
            op = OP_BR_SET;
        end else if ((instr & MSK_REG2) == PAT_BR_CLR) begin
            op = OP_BR_CLR;
        end
    end
endmodule // bcsu_decode
`default_nettype wire

// file: hdl/bcsu_pkg.sv
// Constants and types for the branch, call and skip unit
package bcsu_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_LAST_PC = 8'h08;
    localparam logic [7:0] ADDR_RETIRED = 8'h0c;
    localparam logic RST_ENABLE = 1'b1;
    localparam int CTRL_EN_BIT = 0;
    // ------------------------------------------------------------
    // Status register flag positions
    // ------------------------------------------------------------
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;
    // ------------------------------------------------------------
    // Cycle counts
    // ------------------------------------------------------------
    localparam logic [2:0] CYC_ONE = 3'h1;
    localparam logic [2:0] CYC_TAKEN = 3'h2;
    localparam logic [2:0] CYC_CALL_SHORT = 3'h3;
    localparam logic [2:0] CYC_CALL_DIRECT = 3'h4;
    localparam logic [2:0] CYC_RETURN = 3'h4;
    // ------------------------------------------------------------
    // Opcode masks and patterns
    // ------------------------------------------------------------
    localparam logic [15:0] MSK_REL_CALL = 16'hf000;
    localparam logic [15:0] PAT_REL_CALL = 16'hd000;
    localparam logic [15:0] PAT_IND_CALL = 16'h9509;
    localparam logic [15:0] MSK_DIR_CALL = 16'hfe0e;
    localparam logic [15:0] PAT_DIR_CALL = 16'h940e;
    localparam logic [15:0] PAT_SUB_RET = 16'h9508;
    localparam logic [15:0] PAT_INT_RET = 16'h9518;
    localparam logic [15:0] MSK_REG2 = 16'hfc00;
    localparam logic [15:0] PAT_CMP_SKIP = 16'h1000;
    localparam logic [15:0] PAT_CMP = 16'h1400;
    localparam logic [15:0] PAT_CMP_CARRY = 16'h0400;
    localparam logic [15:0] PAT_CMP_IMM = 16'h3000;
    localparam logic [15:0] MSK_SKIP_REG = 16'hfe08;
    localparam logic [15:0] PAT_SKIP_RBC = 16'hfc00;
    localparam logic [15:0] PAT_SKIP_RBS = 16'hfe00;
    localparam logic [15:0] MSK_SKIP_IO = 16'hff00;
    localparam logic [15:0] PAT_SKIP_IOC = 16'h9900;
    localparam logic [15:0] PAT_SKIP_IOS = 16'h9b00;
    localparam logic [15:0] PAT_BR_SET = 16'hf000;
    localparam logic [15:0] PAT_BR_CLR = 16'hf400;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_ILLEGAL = 4'h0, OP_REL_CALL = 4'h1, OP_IND_CALL = 4'h2,
        OP_DIR_CALL = 4'h3, OP_SUB_RET = 4'h4, OP_INT_RET = 4'h5,
        OP_CMP_SKIP = 4'h6, OP_CMP = 4'h7, OP_CMP_CARRY = 4'h8,
        OP_CMP_IMM = 4'h9, OP_SKIP_RBC = 4'ha, OP_SKIP_RBS = 4'hb,
        OP_SKIP_IOC = 4'hc, OP_SKIP_IOS = 4'hd, OP_BR_SET = 4'he,
        OP_BR_CLR = 4'hf
    } bcsu_op_t;
    typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_EXEC = 1'b1} bcsu_st_t;
    typedef struct packed {
        logic valid;
        logic [15:0] instr;
        logic [15:0] instr2;
        logic [15:0] pc;
        logic [7:0] rd_val;
        logic [7:0] rr_val;
        logic [7:0] io_val;
        logic [15:0] z_ptr;
        logic [15:0] stack_pc;
        logic [7:0] status_register;
        logic next_two_word;
    } bcsu_req_t;
    typedef struct packed {
        logic ready;
        logic done;
        logic [15:0] pc_next;
        logic push;
        logic [15:0] ret_addr;
        logic pop;
        logic [7:0] status_register;
        logic status_register_we;
    } bcsu_res_t;
endpackage

// file: hdl/bcsu_unit.sv
// Branch, call and skip unit with Wishbone control registers
//
// Behaviour
// (RULE1) Relative call to PC+k+1, indirect to Z in 3 cycles, direct to k in 4
// (RULE2) Both returns reload PC from stack in 4 cycles; interrupt return sets I
// (RULE3) Compare-skip-equal skips next word(s) when Rd equals Rr, 1 to 3 cycles
// (RULE4) Compares compute Rd minus operand, update Z N V C H, one cycle
// (RULE5) Skip on register bit clear advances PC by 2 or 3, 1 to 3 cycles
// (RULE6) Skip on register bit set skips next instruction, no flags touched
// (RULE7) Skip on I/O bit clear tests the addressed I/O value bit
// (RULE8) Skip on I/O bit set tests the addressed I/O value bit
// (RULE9) Generic flag branches test status bit s, PC+k+1, 1 or 2 cycles; for s = 4 the unit tests N xor V instead
// (RULE10) Carry branches jump on C set or clear, 1 or 2 cycles
// (RULE11) Minus and plus branches jump on N set or clear
// (RULE12) Signed branches jump on N xor V equal to 0 or 1
// (RULE13) Half-carry branches jump on H set or clear, no flag change
// (RULE14) Transfer-set branch jumps when T is 1, 1 or 2 cycles
// (RULE15) Transfer-clear branch jumps when T is 0, 1 or 2 cycles
// (RULE16) Equal and not-equal branches jump on Z set or clear
//
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module bcsu_unit
    import bcsu_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire bcsu_req_t req,
    output bcsu_res_t res,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        bcsu_st_t st;
        logic [2:0] cnt;
        bcsu_res_t res;
        logic en;
        logic ack;
        logic [31:0] dat;
        logic [2:0] last_cyc;
        logic illegal;
        logic wr_flags;
        logic [15:0] retired;
    } bcsu_state_t;

    bcsu_state_t s_q;
    bcsu_state_t s_d;

    bcsu_op_t op;
    logic [7:0] cmp_status_register;
    logic [7:0] imm8;
    logic [15:0] pc1;
    logic [15:0] rel12;
    logic [15:0] rel7;
    logic [15:0] skip_pc;
    logic [2:0] skip_cyc;
    logic [2:0] bsel;
    logic take;
    logic flag;
    logic taken;
    logic skip;
    logic [15:0] pc_new;
    logic [2:0] cyc_new;

    // ------------------------------------------------------------
    // Decode and compare
    // ------------------------------------------------------------
    bcsu_decode u_decode (
        .instr(req.instr),
        .op(op)
    );

    bcsu_compare u_compare (
        .a(req.rd_val),
        .b((op == OP_CMP_IMM) ? imm8 : req.rr_val),
        .use_carry(op == OP_CMP_CARRY),
        .status_register_in(req.status_register),
        .status_register_out(cmp_status_register)
    );

    // ------------------------------------------------------------
    // Operand fields and targets
    // ------------------------------------------------------------
    assign imm8 = {req.instr[11:8], req.instr[3:0]};
    assign bsel = req.instr[2:0];
    assign pc1 = req.pc + 16'h0001;
    assign rel12 = pc1 + {{4{req.instr[11]}}, req.instr[11:0]}; // RULE1
    assign rel7 = pc1 + {{9{req.instr[9]}}, req.instr[9:3]}; // RULE9
    // Skipping a two-word instruction costs one extra word and cycle
    assign skip_pc = req.pc + (req.next_two_word ? 16'h0003 : 16'h0002);
    assign skip_cyc = req.next_two_word ? 3'h3 : 3'h2;
    assign take = req.valid & s_q.res.ready;

    // ------------------------------------------------------------
    // Branch condition
    // ------------------------------------------------------------
    always_comb begin
        flag = req.status_register[bsel]; // RULE9
        unique case (bsel)
            FLAG_C: flag = req.status_register[FLAG_C]; // RULE10
            FLAG_Z: flag = req.status_register[FLAG_Z]; // RULE16
            FLAG_N: flag = req.status_register[FLAG_N]; // RULE11
            FLAG_V: flag = req.status_register[FLAG_V];
            // Signed test uses N xor V, not a stale S bit
            FLAG_S: flag = req.status_register[FLAG_N] ^ req.status_register[FLAG_V]; // RULE12
            FLAG_H: flag = req.status_register[FLAG_H]; // RULE13
            FLAG_T: flag = req.status_register[FLAG_T]; // RULE14 RULE15
            FLAG_I: flag = req.status_register[FLAG_I];
        endcase
        taken = (op == OP_BR_SET) ? flag : ~flag; // RULE9
    end

    // ------------------------------------------------------------
    // Skip condition
    // ------------------------------------------------------------
    always_comb begin
        skip = 1'b0;
        unique case (op)
            OP_CMP_SKIP: skip = req.rd_val == req.rr_val; // RULE3
            OP_SKIP_RBC: skip = ~req.rr_val[bsel]; // RULE5
            OP_SKIP_RBS: skip = req.rr_val[bsel]; // RULE6
            OP_SKIP_IOC: skip = ~req.io_val[bsel]; // RULE7
            OP_SKIP_IOS: skip = req.io_val[bsel]; // RULE8
            default: skip = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Next PC and cycle count per instruction
    // ------------------------------------------------------------
    always_comb begin
        pc_new = pc1;
        cyc_new = CYC_ONE;
        unique case (op)
            OP_REL_CALL: begin
                pc_new = rel12; // RULE1
                cyc_new = CYC_CALL_SHORT;
            end
            OP_IND_CALL: begin
                pc_new = req.z_ptr; // RULE1
                cyc_new = CYC_CALL_SHORT;
            end
            OP_DIR_CALL: begin
                pc_new = req.instr2; // RULE1
                cyc_new = CYC_CALL_DIRECT;
            end
            OP_SUB_RET, OP_INT_RET: begin
                pc_new = req.stack_pc; // RULE2
                cyc_new = CYC_RETURN;
            end
            OP_CMP_SKIP, OP_SKIP_RBC, OP_SKIP_RBS,
            OP_SKIP_IOC, OP_SKIP_IOS: begin
                pc_new = skip ? skip_pc : pc1; // RULE3 RULE5 RULE6
                cyc_new = skip ? skip_cyc : CYC_ONE; // RULE7 RULE8
            end
            OP_BR_SET, OP_BR_CLR: begin
                pc_new = taken ? rel7 : pc1; // RULE9
                cyc_new = taken ? CYC_TAKEN : CYC_ONE; // RULE9
            end
            OP_CMP, OP_CMP_CARRY, OP_CMP_IMM: begin
                pc_new = pc1; // RULE4
                cyc_new = CYC_ONE; // RULE4
            end
            OP_ILLEGAL: begin
                pc_new = pc1;
                cyc_new = CYC_ONE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer and register file
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.res.done = 1'b0;
        s_d.res.push = 1'b0;
        s_d.res.pop = 1'b0;
        s_d.res.status_register_we = 1'b0;
        s_d.ack = 1'b0;
        unique case (s_q.st)
            ST_IDLE: begin
                if (take) begin
                    s_d.st = ST_EXEC;
                    s_d.cnt = cyc_new - 3'h1;
                    s_d.last_cyc = cyc_new;
                    s_d.illegal = op == OP_ILLEGAL;
                    s_d.wr_flags = op == OP_CMP || op == OP_CMP_CARRY || op == OP_CMP_IMM
                        || op == OP_INT_RET;
                    s_d.res.pc_next = pc_new;
                    s_d.res.status_register = req.status_register;
                    if (op == OP_REL_CALL || op == OP_IND_CALL) begin
                        s_d.res.push = 1'b1; // RULE1
                        s_d.res.ret_addr = pc1;
                    end
                    if (op == OP_DIR_CALL) begin
                        s_d.res.push = 1'b1; // RULE1
                        s_d.res.ret_addr = req.pc + 16'h0002;
                    end
                    if (op == OP_SUB_RET || op == OP_INT_RET) begin
                        s_d.res.pop = 1'b1; // RULE2
                    end
                    if (op == OP_INT_RET) begin
                        s_d.res.status_register[FLAG_I] = 1'b1; // RULE2
                    end
                    if (op == OP_CMP || op == OP_CMP_CARRY || op == OP_CMP_IMM) begin
                        s_d.res.status_register = cmp_status_register; // RULE4
                    end
                end
            end
            ST_EXEC: begin
                if (s_q.cnt == 3'h0) begin
                    s_d.st = ST_IDLE;
                    s_d.res.done = 1'b1;
                    s_d.retired = s_q.retired + 16'h0001;
                    // Only compares and interrupt return write flags back
                    s_d.res.status_register_we = s_q.wr_flags; // RULE2 RULE4
                end else begin
                    s_d.cnt = s_q.cnt - 3'h1;
                end
            end
        endcase
        // Bus slave: one wait state, then ack for exactly one cycle
        if (wb_cyc_i && wb_stb_i && !s_q.ack) begin
            s_d.ack = 1'b1;
            if (wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_CTRL) begin
                s_d.en = wb_dat_i[CTRL_EN_BIT];
            end
            unique case (wb_adr_i)
                ADDR_CTRL: s_d.dat = {31'h0, s_q.en};
                ADDR_STATUS: s_d.dat = {27'h0, s_q.illegal, s_q.last_cyc,
                    s_q.st == ST_EXEC};
                ADDR_LAST_PC: s_d.dat = {16'h0, s_q.res.pc_next};
                ADDR_RETIRED: s_d.dat = {16'h0, s_q.retired};
                default: s_d.dat = 32'h0;
            endcase
        end
        // Disabled unit refuses new instructions after the current one
        s_d.res.ready = s_d.en && s_d.st == ST_IDLE;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.en <= RST_ENABLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign res = s_q.res;
    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.dat;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_rel_call_time: assert property ( // RULE1
        @(posedge core_clk) disable iff (rst)
        take && op == OP_REL_CALL |-> ##4 res.done
            && res.pc_next == $past(rel12, 4))
        else $error("relative call target or timing wrong");

    chk_dir_call_time: assert property ( // RULE1
        @(posedge core_clk) disable iff (rst)
        take && op == OP_DIR_CALL |-> ##1 !res.done [*4] ##1 res.done
            && res.ret_addr == $past(req.pc, 5) + 16'h0002)
        else $error("direct call timing wrong");

    chk_return_pop: assert property ( // RULE2
        @(posedge core_clk) disable iff (rst)
        take && op == OP_INT_RET |-> ##1 res.pop ##4 res.done
            && res.status_register[FLAG_I] && res.pc_next == $past(req.stack_pc, 5))
        else $error("interrupt return wrong");

    chk_cmp_one_cycle: assert property ( // RULE4
        @(posedge core_clk) disable iff (rst)
        take && op == OP_CMP |-> ##2 res.done
            && res.status_register[FLAG_Z] == ($past(req.rd_val, 2) == $past(req.rr_val, 2)))
        else $error("compare result wrong");

    chk_skip_equal: assert property ( // RULE3
        @(posedge core_clk) disable iff (rst)
        take && op == OP_CMP_SKIP && req.rd_val == req.rr_val
            && req.next_two_word |-> ##4 res.done
            && res.pc_next == $past(req.pc, 4) + 16'h0003)
        else $error("compare skip wrong");

    chk_skip_bit_pc: assert property ( // RULE5
        @(posedge core_clk) disable iff (rst)
        take && op == OP_SKIP_RBC && !skip |-> ##2 res.done
            && res.pc_next == $past(pc1, 2))
        else $error("register bit skip wrong");

    chk_branch_taken: assert property ( // RULE9
        @(posedge core_clk) disable iff (rst)
        take && op == OP_BR_SET && taken |-> ##3 res.done
            && res.pc_next == $past(rel7, 3))
        else $error("taken branch wrong");

    chk_branch_signed: assert property ( // RULE12
        @(posedge core_clk) disable iff (rst)
        take && op == OP_BR_CLR && bsel == FLAG_S
            && (req.status_register[FLAG_N] ^ req.status_register[FLAG_V]) |-> ##2 res.done
            && res.pc_next == $past(pc1, 2))
        else $error("signed branch wrong");

    chk_call_push: assert property ( // RULE1
        @(posedge core_clk) disable iff (rst)
        take && (op == OP_REL_CALL || op == OP_IND_CALL) |=> res.push
            && res.ret_addr == $past(pc1))
        else $error("call push or return address wrong");

    chk_skip_io_bit: assert property ( // RULE7
        @(posedge core_clk) disable iff (rst)
        take && op == OP_SKIP_IOC && skip && req.next_two_word |-> ##4 res.done
            && res.pc_next == $past(req.pc, 4) + 16'h0003)
        else $error("I/O bit clear skip wrong");

    chk_io_set_skip: assert property ( // RULE8
        @(posedge core_clk) disable iff (rst)
        take && op == OP_SKIP_IOS && skip && !req.next_two_word |-> ##3 res.done
            && res.pc_next == $past(req.pc, 3) + 16'h0002)
        else $error("I/O bit set skip wrong");

    chk_flags_kept: assert property ( // RULE6
        @(posedge core_clk) disable iff (rst)
        take && op == OP_SKIP_RBS && !skip |-> ##2 res.done && !res.status_register_we
            && res.status_register == $past(req.status_register, 2))
        else $error("register bit skip touched flags");

    chk_branch_half: assert property ( // RULE13
        @(posedge core_clk) disable iff (rst)
        take && op == OP_BR_SET && bsel == FLAG_H && !taken |-> ##2 res.done
            && !res.status_register_we && res.pc_next == $past(pc1, 2))
        else $error("half-carry branch wrong");

    chk_wb_ack_pulse: assert property (
        @(posedge core_clk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
endmodule // bcsu_unit
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the branch, call and skip unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import bcsu_pkg::*;
    // ------------------------------------------------------------
    // Harness
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] i;
        logic [15:0] pc;
        logic [7:0] rd;
        logic [7:0] rr;
        logic [7:0] sr;
        logic tw;
        logic [15:0] epc;
        logic [2:0] ec;
        logic [7:0] esr;
        logic [2:0] k;
    } bcsu_row_t;
    localparam logic [15:0] ZP = 16'h1234;
    localparam logic [15:0] SP = 16'h0abc;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    bcsu_req_t req = '0;
    bcsu_res_t res;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    int miscompares = 0;
    int samples_checked = 0;
    bcsu_unit uut (.core_clk(core_clk), .rst(rst), .req(req), .res(res), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Holds the request until the edge that samples ack, then releases it
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int t;
        t = 0;
        @(posedge core_clk);
        wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= we; wb_adr <= a; wb_dat <= d; wb_sel <= 4'hf;
        do begin
            @(posedge core_clk);
            t++;
        end while (wb_ack_o !== 1'b1 && t < 50);
        chk(32'(wb_ack_o), 32'h1, "bus ack");
        q = wb_dat_o;
        wb_cyc <= 1'b0; wb_stb <= 1'b0; wb_we <= 1'b0;
    endtask
    // Offers one instruction, counts edges from the take edge to the one raising done
    task automatic run(input bcsu_row_t r);
        int n;
        logic [2:0] seen;
        logic [15:0] ra;
        n = 0; seen = 3'h0; ra = 16'h0;
        @(posedge core_clk);
        req <= '{1'b1, r.i, 16'h0456, r.pc, r.rd, r.rr, r.rr, ZP, SP, r.sr, r.tw};
        do @(negedge core_clk); while (res.ready !== 1'b1 && ++n < 50);
        @(posedge core_clk);
        req.valid <= 1'b0;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
            seen = seen | {res.push, res.pop, res.status_register_we};
            if (res.push === 1'b1) ra = res.ret_addr;
        end while (res.done !== 1'b1 && n < 9);
        chk(32'(n - 1), 32'(r.ec), "cycle count");
        chk(32'(res.pc_next), 32'(r.epc), "next pc");
        chk(32'(res.status_register & 8'hef), 32'(r.esr & 8'hef), "flags");
        chk(32'(seen), 32'(r.k), "stack and flag strobes");
        if (r.k[2]) chk(32'(ra), 32'(r.pc + ((r.i == PAT_DIR_CALL) ? 16'h2 : 16'h1)), "ret");
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    bcsu_row_t rows [16] = '{
        '{16'hdffe, 16'h0100, 8'h00, 8'h00, 8'h00, 1'b0, 16'h00ff, 3'h3, 8'h00, 3'h4},
        '{16'h9509, 16'h0100, 8'h00, 8'h00, 8'h00, 1'b0, ZP, 3'h3, 8'h00, 3'h4},
        '{16'h940e, 16'h0100, 8'h00, 8'h00, 8'h5a, 1'b0, 16'h0456, 3'h4, 8'h5a, 3'h4},
        '{16'h9508, 16'h0100, 8'h00, 8'h00, 8'h00, 1'b0, SP, 3'h4, 8'h00, 3'h2},
        '{16'h9518, 16'h0100, 8'h00, 8'h00, 8'h01, 1'b0, SP, 3'h4, 8'h81, 3'h3},
        '{16'h1000, 16'h0100, 8'h33, 8'h33, 8'h00, 1'b1, 16'h0103, 3'h3, 8'h00, 3'h0},
        '{16'h1000, 16'h0100, 8'h33, 8'h33, 8'h00, 1'b0, 16'h0102, 3'h2, 8'h00, 3'h0},
        '{16'h1000, 16'h0100, 8'h33, 8'h34, 8'hff, 1'b0, 16'h0101, 3'h1, 8'hff, 3'h0},
        '{16'h1400, 16'h0100, 8'h10, 8'h20, 8'h00, 1'b0, 16'h0101, 3'h1, 8'h05, 3'h1},
        '{16'h0400, 16'h0100, 8'h05, 8'h04, 8'h03, 1'b0, 16'h0101, 3'h1, 8'h02, 3'h1},
        '{16'h3800, 16'h0100, 8'h00, 8'h00, 8'h00, 1'b0, 16'h0101, 3'h1, 8'h0d, 3'h1},
        '{16'hfc03, 16'h0100, 8'h00, 8'hf7, 8'h00, 1'b0, 16'h0102, 3'h2, 8'h00, 3'h0},
        '{16'hfe07, 16'h0100, 8'h00, 8'h7f, 8'hc3, 1'b0, 16'h0101, 3'h1, 8'hc3, 3'h0},
        '{16'h9905, 16'h0100, 8'h00, 8'hdf, 8'h00, 1'b1, 16'h0103, 3'h3, 8'h00, 3'h0},
        '{16'h9b00, 16'h0100, 8'h00, 8'h01, 8'h00, 1'b0, 16'h0102, 3'h2, 8'h00, 3'h0},
        '{16'h0000, 16'h0100, 8'h00, 8'h00, 8'h00, 1'b0, 16'h0101, 3'h1, 8'h00, 3'h0}};
    logic [7:0] pat [3] = '{8'ha5, 8'h5a, 8'h00};
    initial begin
        bcsu_row_t b;
        logic f;
        logic [31:0] q;
        repeat (10) @(posedge core_clk);
        chk(32'({res, wb_ack_o, wb_dat_o} != '0), 32'h0, "outputs in reset");
        rst <= 1'b0;
        foreach (rows[n]) run(rows[n]);
        // S position tests N xor V, so a5 separates it from bit 4
        foreach (pat[p]) for (int s = 0; s < 8; s++) for (int c = 0; c < 2; c++) begin
            f = ((s == 4) ? (pat[p][2] ^ pat[p][3]) : pat[p][s]) ^ c[0];
            b = '{(c[0] ? PAT_BR_CLR : PAT_BR_SET) | {6'h00, 7'h7d, 3'(s)}, 16'h0100, 8'h00,
                8'h00, pat[p], 1'b0, f ? 16'h00fe : 16'h0101, f ? 3'h2 : 3'h1, pat[p], 3'h0};
            run(b);
        end
        wb(1'b0, ADDR_CTRL, 32'h0, q);
        chk(q, 32'h1, "ctrl reset value");
        wb(1'b0, ADDR_LAST_PC, 32'h0, q);
        chk(q, 32'h00fe, "last pc");
        wb(1'b0, ADDR_RETIRED, 32'h0, q);
        chk(q, 32'h40, "retired count");
        wb(1'b1, ADDR_STATUS, 32'hff, q);
        wb(1'b0, ADDR_STATUS, 32'h0, q);
        chk(q, 32'h4, "status read only, last count");
        wb(1'b0, 8'h10, 32'h0, q);
        chk(q, 32'h0, "unmapped read");
        wb(1'b1, ADDR_CTRL, 32'h0, q);
        @(posedge core_clk);
        req <= '{1'b1, 16'h0000, 16'h0, 16'h0100, 8'h0, 8'h0, 8'h0, ZP, SP, 8'h0, 1'b0};
        repeat (6) begin
            @(negedge core_clk);
            chk(32'({res.ready, res.done}), 32'h0, "disabled unit took a request");
        end
        @(posedge core_clk);
        req.valid <= 1'b0;
        wb(1'b1, ADDR_CTRL, 32'h1, q);
        run(rows[0]);
        tally_and_finish();
    end
    // Whole run is a few hundred cycles; this leaves ample margin
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
